// ### cpu_model.sv
// processor-side model of the memory-mapped register port
// assumes the bench clock; requests change 1 ns after a rising edge
module cpu_model
(
    // clock
    input wire logic clock,
    // register port
    output logic reg_write,
    output logic [2:0] reg_addr,
    output logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        reg_write = 1'b0;
        reg_addr = 3'h7;
        reg_wdata = 16'h0000;
    end

    // one-cycle write pulse, 8-bit registers take the low byte
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge clock);
        #1;
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clock);
        #1;
        reg_write = 1'b0;
        // released data must not keep showing the old word
        reg_wdata = ~d;
    endtask : wr

    // read data answers one edge after the address
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge clock);
        #1;
        reg_addr = a;
        @(posedge clock);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : cpu_model

// ### fsk_synth.sv
// two-tone phase-continuous sine synthesiser
// assumes dds_tick is a one-cycle pulse at the synthesiser rate
module fsk_synth
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic dds_tick,
    input wire logic tx_active,
    input wire logic bit_value,
    input wire logic [15:0] mark_step,
    input wire logic [15:0] space_step,
    // output
    output logic signed [11:0] sample,
    output logic running
);
    logic [mains_sync_pkg::PHASE_W-1:0] phase;
    logic [mains_sync_pkg::PHASE_W:0] phase_sum;
    logic wrap;
    logic [10:0] mag;
    logic [3:0] sidx;

    // mark for a one, space for a zero
    assign phase_sum = {1'b0, phase} +
        {3'h0, (bit_value ? mark_step : space_step)};
    assign wrap = phase_sum[mains_sync_pkg::PHASE_W];

    // start from zero, never reset on a tone change, finish period on rx
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            running <= 1'b0;
            phase <= '0;
        end
        else if (!running)
        begin
            running <= tx_active;
            phase <= '0;
        end
        else if (dds_tick)
        begin
            if (!tx_active && wrap)
            begin
                running <= 1'b0;
                phase <= '0;
            end
            else
                phase <= phase_sum[mains_sync_pkg::PHASE_W-1:0];
        end
    end

    assign sidx = phase[16] ? ~phase[15:12] : phase[15:12];
    assign mag = mains_sync_pkg::quarter_sine(sidx);

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sample <= '0;
        else if (!running)
            sample <= '0;
        else
            sample <= phase[17] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
    end

    a_start_zero: assert property (@(posedge clock) disable iff (rst)
        !running && tx_active |=> running && phase == '0)
        else $error("synth did not start at zero phase");
    a_rx_finish: assert property (@(posedge clock) disable iff (rst)
        running && !tx_active && !(dds_tick && wrap) |=> running)
        else $error("synth stopped mid period");
    a_rx_silent: assert property (@(posedge clock) disable iff (rst)
        !running ##1 !running |-> sample == '0)
        else $error("synth output not silent in receive");

endmodule : fsk_synth

// ### mains_sync_pkg.sv
// constants shared by the mains-synchronised timing core and its synthesiser
// assumes a single base clock; all times are converted to cycles here
package mains_sync_pkg;

    // base clock and derived rates, in kHz
    localparam int BASE_CLK_KHZ = 40000;
    localparam int TX_CLK_DIV = 4;
    localparam int TX_CLK_KHZ = BASE_CLK_KHZ / TX_CLK_DIV;
    localparam int DDS_CLK_KHZ = 3000;
    localparam int DDS_FRAC_W = 14;

    // falling-edge de-bounce, least time, rounded up
    localparam int DEBOUNCE_TIME_US = 500;
    localparam int DEBOUNCE_CYCLES =
        (DEBOUNCE_TIME_US * BASE_CLK_KHZ + 999) / 1000;

    // phase advance granularity
    localparam int ADV_STEP_US = 13;
    localparam int ADV_STEP_CYCLES = (ADV_STEP_US * BASE_CLK_KHZ) / 1000;

    // mains period bookkeeping
    localparam int PERIOD_W = 20;
    localparam int MAINS_50_HZ = 50;
    localparam int MAINS_60_HZ = 60;
    localparam int PERIOD_50 = BASE_CLK_KHZ * 1000 / MAINS_50_HZ;
    localparam int PERIOD_60 = BASE_CLK_KHZ * 1000 / MAINS_60_HZ;
    localparam int WINDOW_SHIFT = 3;
    localparam int FILTER_SHIFT = 2;

    // symbol clocks per mains period: 8 per bit, 6/12/24/48 bits
    localparam logic [8:0] CHIPS_BASE = 9'h030;
    localparam int CHIPS_PER_BIT = 8;

    // frame counter
    localparam int FRAME_W = 12;
    localparam logic [11:0] FRAME_LAST = 12'hb3f;
    localparam logic [11:0] EARLY_FRAME_VALUE = 12'hb38;
    localparam logic [5:0] EARLY_BYTE_PHASE = 6'h38;

    // register indices on the memory-mapped port
    localparam logic [2:0] REG_CONFIG = 3'h0;
    localparam logic [2:0] REG_ADVANCE = 3'h1;
    localparam logic [2:0] REG_TX_DATA = 3'h2;
    localparam logic [2:0] REG_MARK = 3'h3;
    localparam logic [2:0] REG_SPACE = 3'h4;
    localparam logic [2:0] REG_CONTROL = 3'h5;
    localparam logic [2:0] REG_STATUS = 3'h6;

    // field positions and reset values
    localparam int CFG_MAINS_60 = 0;
    localparam int CFG_RATE_LO = 1;
    localparam int CFG_SYNC_OFF = 7;
    localparam int CTRL_TRANSMIT = 0;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] ADVANCE_RESET = 8'h00;
    localparam logic [15:0] STEP_RESET = 16'h0000;

    // synthesiser
    localparam int PHASE_W = 18;
    localparam int SAMPLE_W = 12;

    // one quarter of a sine, 16 points, amplitude 2047
    function automatic logic [10:0] quarter_sine(input logic [3:0] idx);
        case (idx)
            4'h0: quarter_sine = 11'h000;
            4'h1: quarter_sine = 11'h0c9;
            4'h2: quarter_sine = 11'h18f;
            4'h3: quarter_sine = 11'h252;
            4'h4: quarter_sine = 11'h30f;
            4'h5: quarter_sine = 11'h3c5;
            4'h6: quarter_sine = 11'h471;
            4'h7: quarter_sine = 11'h513;
            4'h8: quarter_sine = 11'h5a7;
            4'h9: quarter_sine = 11'h62e;
            4'ha: quarter_sine = 11'h6a6;
            4'hb: quarter_sine = 11'h70d;
            4'hc: quarter_sine = 11'h763;
            4'hd: quarter_sine = 11'h7a7;
            4'he: quarter_sine = 11'h7d8;
            default: quarter_sine = 11'h7f5;
        endcase
    endfunction : quarter_sine

endpackage : mains_sync_pkg

// ### mains_sync_timing.sv
// mains-locked symbol clock, frame timing strobes and fsk transmit core
// assumes mains_sense_pin is already synchronous to clock; the processor
// writes and reads registers over the plain memory-mapped port below
// Operation
// - falling comparator edges de-bounced 0.5 to 1 ms, rising edges pass
// - loop makes the symbol clock at eight times the bit rate
// - config bit 0 picks 50 or 60 Hz and loop filter window
// - config bits 2:1 pick 6, 12, 24 or 48 bits per period
// - only rising comparator edges steer the loop
// - without crossings the period estimate freezes and the clock runs on
// - with zero advance the symbol clock lines up with rising edges
// - advance register moves symbol clock earlier by value times 13 us
// - frame counter kept across receive and transmit switching
// - bit strobe at counter multiples of 8, 0 to 2872
// - byte strobe at counter multiples of 64, 0 to 2816
// - frame strobe only at counter zero
// - early byte strobe eight symbol clocks before each byte strobe
// - early frame strobe eight symbol clocks before the frame strobe
// - lead window from early frame to frame, on sync pin if bit7 clear
// - transmit select high means transmit, low means receive
// - modulator inactive in receive mode
// - space tone for a zero, mark tone for a one, 16-bit steps
// - tone equals step times 3 MHz over two to the eighteenth
// - accumulator starts at zero; tone changes keep phase continuous
// - on switching to receive the current sine period completes
// - everything runs from the base clock; tx clock is base over four
module mains_sync_timing
#(
    parameter int DEBOUNCE_CYCLES = mains_sync_pkg::DEBOUNCE_CYCLES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // mains sense and sync pins
    input wire logic mains_sense_pin,
    output logic sync_output_pin,
    // memory-mapped register port
    input wire logic reg_write,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // timing strobes
    output logic chip_tick,
    output logic bit_strobe,
    output logic byte_strobe,
    output logic frame_strobe,
    output logic early_byte_strobe,
    output logic early_frame_strobe,
    output logic frame_lead_window,
    // transmit side
    output logic transmit_select,
    output logic signed [11:0] tx_sample,
    output logic tx_running
);
    localparam int PW = mains_sync_pkg::PERIOD_W;
    localparam int FW = mains_sync_pkg::FRAME_W;

    logic [7:0] mains_sync_config;
    logic [7:0] zero_cross_phase_advance;
    logic [7:0] tx_bit_data;
    logic [15:0] mark_freq_step;
    logic [15:0] space_freq_step;

    logic sense_filt;
    logic [PW-1:0] deb_cnt;
    logic zc_rise;
    logic [PW-1:0] since_edge;
    logic [PW-1:0] period_est;
    logic [PW-1:0] phase_cnt;
    logic [PW-1:0] nco_acc;
    logic [PW:0] nco_sum;
    logic [8:0] chips;
    logic [PW-1:0] adv_cycles;
    logic [PW-1:0] nominal;
    logic resync;
    logic [FW-1:0] frame_cnt;
    logic [FW-1:0] next_frame;
    logic [1:0] tx_div;
    logic tx_tick;
    logic [mains_sync_pkg::DDS_FRAC_W-1:0] dds_frac;
    logic dds_tick;
    logic tx_bit;
    logic cfg_write;

    assign cfg_write = reg_write && reg_addr == mains_sync_pkg::REG_CONFIG;

    // register writes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            mains_sync_config <= mains_sync_pkg::CONFIG_RESET;
            zero_cross_phase_advance <= mains_sync_pkg::ADVANCE_RESET;
            tx_bit_data <= '0;
            mark_freq_step <= mains_sync_pkg::STEP_RESET;
            space_freq_step <= mains_sync_pkg::STEP_RESET;
            transmit_select <= 1'b0;
        end
        else if (reg_write)
        begin
            case (reg_addr)
                mains_sync_pkg::REG_CONFIG:
                    mains_sync_config <= reg_wdata[7:0];
                mains_sync_pkg::REG_ADVANCE:
                    zero_cross_phase_advance <= reg_wdata[7:0];
                mains_sync_pkg::REG_TX_DATA:
                    tx_bit_data <= reg_wdata[7:0];
                mains_sync_pkg::REG_MARK:
                    mark_freq_step <= reg_wdata;
                mains_sync_pkg::REG_SPACE:
                    space_freq_step <= reg_wdata;
                mains_sync_pkg::REG_CONTROL:
                    transmit_select <=
                        reg_wdata[mains_sync_pkg::CTRL_TRANSMIT];
                default:
                    transmit_select <= transmit_select;
            endcase
        end
    end

    // register reads, one cycle after the address
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else
        begin
            case (reg_addr)
                mains_sync_pkg::REG_CONFIG:
                    reg_rdata <= {8'h00, mains_sync_config};
                mains_sync_pkg::REG_ADVANCE:
                    reg_rdata <= {8'h00, zero_cross_phase_advance};
                mains_sync_pkg::REG_TX_DATA:
                    reg_rdata <= {8'h00, tx_bit_data};
                mains_sync_pkg::REG_MARK:
                    reg_rdata <= mark_freq_step;
                mains_sync_pkg::REG_SPACE:
                    reg_rdata <= space_freq_step;
                mains_sync_pkg::REG_CONTROL:
                    reg_rdata <= {15'h0000, transmit_select};
                mains_sync_pkg::REG_STATUS:
                    reg_rdata <= {tx_running, 3'h0, frame_cnt};
                default:
                    reg_rdata <= '0;
            endcase
        end
    end

    // rising edge passes at once; low must hold for the de-bounce time
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            sense_filt <= 1'b0;
            deb_cnt <= '0;
        end
        else if (mains_sense_pin)
        begin
            sense_filt <= 1'b1;
            deb_cnt <= '0;
        end
        else if (sense_filt)
        begin
            if (deb_cnt == PW'(DEBOUNCE_CYCLES - 1))
            begin
                sense_filt <= 1'b0;
                deb_cnt <= '0;
            end
            else
                deb_cnt <= deb_cnt + 1'b1;
        end
    end

    assign zc_rise = mains_sense_pin && !sense_filt;

    // nominal period and acceptance window follow the mains selection
    assign nominal = mains_sync_config[mains_sync_pkg::CFG_MAINS_60] ?
        PW'(mains_sync_pkg::PERIOD_60) : PW'(mains_sync_pkg::PERIOD_50);
    assign chips = mains_sync_pkg::CHIPS_BASE <<
        mains_sync_config[mains_sync_pkg::CFG_RATE_LO +: 2];
    assign adv_cycles = PW'(zero_cross_phase_advance *
        mains_sync_pkg::ADV_STEP_CYCLES);

    // period measure and filter; a jittery edge only moves the estimate by
    // a quarter of its error, which is what smooths the symbol clock
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            since_edge <= '0;
            period_est <= PW'(mains_sync_pkg::PERIOD_50);
        end
        else
        begin
            if (zc_rise)
                since_edge <= '0;
            else if (since_edge != '1)
                since_edge <= since_edge + 1'b1;
            if (cfg_write)
                period_est <= reg_wdata[mains_sync_pkg::CFG_MAINS_60] ?
                    PW'(mains_sync_pkg::PERIOD_60) :
                    PW'(mains_sync_pkg::PERIOD_50);
            else if (zc_rise &&
                since_edge > nominal - (nominal >> mains_sync_pkg::WINDOW_SHIFT) &&
                since_edge < nominal + (nominal >> mains_sync_pkg::WINDOW_SHIFT))
                period_est <= PW'($signed({1'b0, period_est}) +
                    ($signed({1'b0, since_edge} - {1'b0, period_est}) >>>
                    mains_sync_pkg::FILTER_SHIFT));
        end
    end

    // flywheel: restarts on a real edge, else wraps on the estimate
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            phase_cnt <= '0;
        else if (zc_rise)
            phase_cnt <= '0;
        else if (phase_cnt >= period_est - 1'b1)
            phase_cnt <= '0;
        else
            phase_cnt <= phase_cnt + 1'b1;
    end

    // alignment point sits adv_cycles ahead of the expected edge
    assign resync = (zero_cross_phase_advance == '0) ?
        (zc_rise || (phase_cnt >= period_est - 1'b1)) :
        (phase_cnt == period_est - adv_cycles);
    assign nco_sum = {1'b0, nco_acc} + {{(PW-8){1'b0}}, chips};

    // fractional divider: chips ticks per estimated period
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            nco_acc <= '0;
            chip_tick <= 1'b0;
        end
        else if (resync)
        begin
            nco_acc <= '0;
            chip_tick <= 1'b1;
        end
        else if (nco_sum >= {1'b0, period_est})
        begin
            nco_acc <= PW'(nco_sum - {1'b0, period_est});
            chip_tick <= 1'b1;
        end
        else
        begin
            nco_acc <= nco_sum[PW-1:0];
            chip_tick <= 1'b0;
        end
    end

    // frame counter is never touched by the transmit select
    assign next_frame = (frame_cnt == mains_sync_pkg::FRAME_LAST) ?
        '0 : frame_cnt + 1'b1;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            frame_cnt <= '0;
        else if (chip_tick)
            frame_cnt <= next_frame;
    end

    // strobes are one cycle, on the tick that enters the value
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            bit_strobe <= 1'b0;
            byte_strobe <= 1'b0;
            frame_strobe <= 1'b0;
            early_byte_strobe <= 1'b0;
            early_frame_strobe <= 1'b0;
        end
        else
        begin
            bit_strobe <= chip_tick && next_frame[2:0] == '0;
            byte_strobe <= chip_tick && next_frame[5:0] == '0;
            frame_strobe <= chip_tick && next_frame == '0;
            early_byte_strobe <= chip_tick &&
                next_frame[5:0] == mains_sync_pkg::EARLY_BYTE_PHASE;
            early_frame_strobe <= chip_tick &&
                next_frame == mains_sync_pkg::EARLY_FRAME_VALUE;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            frame_lead_window <= 1'b0;
        else if (frame_strobe)
            frame_lead_window <= 1'b0;
        else if (early_frame_strobe)
            frame_lead_window <= 1'b1;
    end

    assign sync_output_pin = frame_lead_window &&
        !mains_sync_config[mains_sync_pkg::CFG_SYNC_OFF];

    // tx clock is base over four; synthesiser tick is a fractional
    // divide of it so the step rate stays at 3 MHz while the tx clock is from 3 MHz up to 2^14 kHz
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tx_div <= '0;
            dds_frac <= '0;
            dds_tick <= 1'b0;
        end
        else
        begin
            tx_div <= tx_div + 1'b1;
            if (tx_tick && {1'b0, dds_frac} +
                (mains_sync_pkg::DDS_FRAC_W+1)'(mains_sync_pkg::DDS_CLK_KHZ) >=
                (mains_sync_pkg::DDS_FRAC_W+1)'(mains_sync_pkg::TX_CLK_KHZ))
            begin
                dds_frac <= mains_sync_pkg::DDS_FRAC_W'(dds_frac +
                    mains_sync_pkg::DDS_CLK_KHZ - mains_sync_pkg::TX_CLK_KHZ);
                dds_tick <= 1'b1;
            end
            else
            begin
                if (tx_tick)
                    dds_frac <= mains_sync_pkg::DDS_FRAC_W'(dds_frac +
                        mains_sync_pkg::DDS_CLK_KHZ);
                dds_tick <= 1'b0;
            end
        end
    end

    assign tx_tick = tx_div == 2'(mains_sync_pkg::TX_CLK_DIV - 1);

    // bits go out msb first, one per bit strobe
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            tx_bit <= 1'b0;
        else if (chip_tick && next_frame[2:0] == '0)
            tx_bit <= tx_bit_data[3'h7 - next_frame[5:3]];
    end

    fsk_synth synth
    (
        .clock(clock),
        .rst(rst),
        .dds_tick(dds_tick),
        .tx_active(transmit_select),
        .bit_value(tx_bit),
        .mark_step(mark_freq_step),
        .space_step(space_freq_step),
        .sample(tx_sample),
        .running(tx_running)
    );

    a_rise_passes: assert property (@(posedge clock) disable iff (rst)
        mains_sense_pin && !sense_filt |=> sense_filt)
        else $error("rising edge was delayed");
    a_fall_debounced: assert property (@(posedge clock) disable iff (rst)
        $fell(sense_filt) |-> $past(deb_cnt) == PW'(DEBOUNCE_CYCLES - 1))
        else $error("falling edge passed before de-bounce time");
    a_zero_adv_align: assert property (@(posedge clock) disable iff (rst)
        zc_rise && zero_cross_phase_advance == '0 |=> chip_tick)
        else $error("symbol clock not aligned to rising edge");
    a_frame_wrap: assert property (@(posedge clock) disable iff (rst)
        chip_tick && frame_cnt == mains_sync_pkg::FRAME_LAST
        |=> frame_cnt == '0 && frame_strobe)
        else $error("frame counter did not wrap into a frame strobe");
    a_bit_place: assert property (@(posedge clock) disable iff (rst)
        bit_strobe |-> frame_cnt[2:0] == '0)
        else $error("bit strobe off an 8 boundary");
    a_byte_place: assert property (@(posedge clock) disable iff (rst)
        byte_strobe |-> bit_strobe && frame_cnt[5:0] == '0)
        else $error("byte strobe off a 64 boundary");
    a_early_frame: assert property (@(posedge clock) disable iff (rst)
        early_frame_strobe |-> frame_cnt == mains_sync_pkg::EARLY_FRAME_VALUE
        && early_byte_strobe)
        else $error("early frame strobe at wrong count");
    a_lead_window: assert property (@(posedge clock) disable iff (rst)
        $rose(frame_lead_window) |-> $past(early_frame_strobe))
        else $error("lead window opened without early frame strobe");
    a_freeze: assert property (@(posedge clock) disable iff (rst)
        !zc_rise && !cfg_write |=> $stable(period_est))
        else $error("period estimate moved without an edge");

endmodule : mains_sync_timing

// ### mains_sync_timing_tb.sv
// bench for the mains-locked timing core and fsk synthesiser
// assumes a shortened de-bounce; mains edges are forced fast
module mains_sync_timing_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEB = 16;
    logic clock, rst, mains_sense_pin, sync_output_pin, reg_write;
    logic chip_tick, bit_strobe, byte_strobe, frame_strobe;
    logic early_byte_strobe, early_frame_strobe, frame_lead_window;
    logic transmit_select, tx_running, sync_on;
    logic [2:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, d;
    logic signed [11:0] tx_sample;
    int n_mismatch = 0;
    int cmp_count = 0;
    int nt = 0, nb = 0, ny = 0, nf = 0, ney = 0, nef = 0, nw = 0, nbad = 0;
    int t0;
    logic [15:0] val[5] = '{16'h0085, 16'h00ff, 16'h005a, 16'hffff, 16'h0001};

    mains_sync_timing #(.DEBOUNCE_CYCLES(DEB)) mains_sync_timing_i (
        .clock(clock), .rst(rst), .mains_sense_pin(mains_sense_pin),
        .sync_output_pin(sync_output_pin), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .chip_tick(chip_tick), .bit_strobe(bit_strobe),
        .byte_strobe(byte_strobe), .frame_strobe(frame_strobe),
        .early_byte_strobe(early_byte_strobe),
        .early_frame_strobe(early_frame_strobe),
        .frame_lead_window(frame_lead_window),
        .transmit_select(transmit_select), .tx_sample(tx_sample),
        .tx_running(tx_running));
    cpu_model cpu_model_i (.clock(clock), .reg_write(reg_write),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock)
    begin
        if (!rst)
        begin
            nt += chip_tick;
            nb += bit_strobe;
            ny += byte_strobe;
            nf += frame_strobe;
            ney += early_byte_strobe;
            nef += early_frame_strobe;
            nw += chip_tick & frame_lead_window;
            nbad += (frame_strobe & ~byte_strobe) | (byte_strobe & ~bit_strobe);
            nbad += sync_on & (sync_output_pin != frame_lead_window);
        end
    end

    task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // comparator low for lo cycles, then a rising edge held high
    task automatic pulse(input int lo);
        mains_sense_pin = 1'b0;
        repeat (lo) @(posedge clock);
        #1;
        mains_sense_pin = 1'b1;
        repeat (3) @(posedge clock);
        #1;
    endtask : pulse

    task automatic results;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : results

    initial
    begin
        rst = 1'b1;
        mains_sense_pin = 1'b0;
        sync_on = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        for (int a = 0; a < 6; a++)
        begin
            cpu_model_i.rd(a[2:0], d);
            chk("reset value", 16'h0000, d);
        end
        chk("mode", 16'h0000, {14'h0, transmit_select, tx_running});
        // 2876 edge-driven symbol ticks, stopping inside the frame lead window
        repeat (2876) pulse(20);
        chk("sync pin", 16'h0001, {15'h0, sync_output_pin});
        sync_on = 1'b0;
        cpu_model_i.wr(3'h0, 16'h0080);
        chk("sync pin off", 16'h0000, {15'h0, sync_output_pin});
        cpu_model_i.wr(3'h0, 16'h0000);
        sync_on = 1'b1;
        repeat (4) pulse(20);
        chk("ticks", 16'd2880, 16'(nt));
        chk("bit strobes", 16'd360, 16'(nb));
        chk("byte strobes", 16'd45, 16'(ny));
        chk("frame strobes", 16'd1, 16'(nf));
        chk("early bytes", 16'd45, 16'(ney));
        chk("early frames", 16'd1, 16'(nef));
        chk("lead ticks", 16'd8, 16'(nw));
        chk("strobe pairing", 16'd0, 16'(nbad));
        // transmit burst, then back to receive
        cpu_model_i.wr(3'h3, 16'h4000);
        cpu_model_i.wr(3'h4, 16'h2000);
        cpu_model_i.wr(3'h2, 16'h00a5);
        cpu_model_i.wr(3'h5, 16'h0001);
        // the synthesiser follows the registered select one edge later
        @(posedge clock);
        #1;
        chk("tx start", 16'h0003, {14'h0, transmit_select, tx_running});
        chk("first sample", 16'h0000, 16'(tx_sample));
        cpu_model_i.rd(3'h6, d);
        chk("status in tx", 16'h8000, d);
        for (int i = 0; i < 200 && tx_sample === 12'sh000; i++) @(posedge clock);
        #1;
        chk("tone", 16'h0001, {15'h0, tx_sample !== 12'sh000});
        cpu_model_i.wr(3'h5, 16'h0000);
        chk("rx select", 16'h0000, {15'h0, transmit_select});
        for (int i = 0; i < 1000 && tx_running !== 1'b0; i++) @(posedge clock);
        #1;
        chk("synth stop", 16'h0000, {15'h0, tx_running});
        chk("idle sample", 16'h0000, 16'(tx_sample));
        cpu_model_i.rd(3'h6, d);
        chk("status in rx", 16'h0000, d);
        // advanced alignment, short glitch, real edge
        cpu_model_i.wr(3'h1, 16'h0001);
        t0 = nt;
        pulse(20);
        chk("advanced tick", 16'h0000, 16'(nt - t0));
        cpu_model_i.wr(3'h1, 16'h0000);
        t0 = nt;
        pulse(DEB / 2);
        chk("glitch", 16'h0000, 16'(nt - t0));
        pulse(DEB + 4);
        chk("edge tick", 16'h0001, 16'(nt - t0));
        // back-to-back writes, read-back, unmapped place
        for (int a = 0; a < 5; a++)
            cpu_model_i.wr(a[2:0], val[a]);
        cpu_model_i.wr(3'h7, 16'h1234);
        for (int a = 0; a < 5; a++)
        begin
            cpu_model_i.rd(a[2:0], d);
            chk("read back", val[a], d);
        end
        cpu_model_i.rd(3'h7, d);
        chk("unmapped", 16'h0000, d);
        results();
    end
endmodule : mains_sync_timing_tb
